// ---- design/drive_status_consts.svh ----
`ifndef DRIVE_STATUS_CONSTS_SVH
`define DRIVE_STATUS_CONSTS_SVH

// Object index of the status word
`define SW_INDEX            16'h6041

// State masks and the values shown under them
`define SW_MASK_WIDE        16'h004F
`define SW_MASK_NARROW      16'h006F
`define SW_VAL_NOT_PREP     16'h0000
`define SW_VAL_DISABLED     16'h0040
`define SW_VAL_PREPARED     16'h0021
`define SW_VAL_SWITCHED_ON  16'h0023
`define SW_VAL_OP_ENABLED   16'h0027
`define SW_VAL_QUICK_STOP   16'h0007
`define SW_VAL_FAULT_LEGACY 16'h000F
`define SW_VAL_FAULT_STD    16'h0008

// Event flag bit positions in the status word
`define SW_BIT_POWER_STAGE  4
`define SW_BIT_WARNING      7
`define SW_BIT_MOTION       8
`define SW_BIT_NET_ENABLE   9
`define SW_BIT_GOAL         10
`define SW_BIT_CUR_LIMIT    11
`define SW_BIT_MODE_ACK     12
`define SW_BIT_TRACK_ERR    13
`define SW_BIT_VENDOR       14
`define SW_BIT_CAPTURE      15

// Compatibility setting bits
`define COMPAT_BIT_POWER    7
`define COMPAT_BIT_FAULT    6

// Control word bit positions
`define CW_BIT_VOLTAGE      1
`define CW_BIT_QSTOP        2
`define CW_BIT_ENABLE_OP    3
`define CW_BIT_FAULT_RST    7

// Reset values
`define SW_RESET_WORD       16'h0000

`endif

// ---- design/drive_status_pkg.sv ----
package drive_status_pkg;

	// Gray along not prepared -> disabled -> prepared -> on -> enabled
	typedef enum logic [2:0] {
		not_prepared_state  = 3'h0,
		disabled_state      = 3'h1,
		prepared_state      = 3'h3,
		switched_on_state   = 3'h2,
		op_enabled_state    = 3'h6,
		quick_stop_state    = 3'h7,
		fault_react_state   = 3'h5,
		fault_state         = 3'h4
	} drive_state_t;

	typedef struct packed {
		logic power_stage_on;
		logic warning;
		logic motion_flag;
		logic network_enable;
		logic goal_attained;
		logic current_limit;
		logic mode_ack;
		logic track_error;
		logic vendor_flag;
		logic capture_result;
	} event_flags_t;

	typedef struct packed {
		logic        ack;
		logic        err;
		logic [15:0] data;
	} obj_read_t;

	typedef struct packed {
		drive_state_t state;
		logic         fault_rst_prev;
		logic [15:0]  word;
		obj_read_t    rd;
	} encoder_core_t;

endpackage : drive_status_pkg

// ---- design/drive_status_word_encoder.sv ----
// Overview of operation
// RQ1: State is coded jointly in bits 0,1,2,3,5,6, never by one bit.
// RQ2: Under mask 004F show 0000 not prepared, 0040 switch-on disabled.
// RQ3: Under mask 006F show 0021 prepared, 0023 switched on.
// RQ4: Under mask 006F show 0027 enabled, 0007 quick stop.
// RQ5: Legacy mode shows fault reaction and fault both as 000F.
// RQ6: Standard fault option shows fault as 0008 under mask 004F.
// RQ7: Legacy fault indication stays unless the compatibility option changes.
// RQ8: Master ANDs status with state mask before comparing.
// RQ9: Master writes 0006, waits 0021, then writes 000F, waits 0027.
// RQ10: No status bit is latched; each shows the present condition.
// RQ11: Event flags sit at bits 4 and 7 through 15.
// RQ12: Master sends no new state command until the previous one shows.
// RQ13: State bits follow the state register in the same cycle.
`timescale 1ns/10ps
`include "drive_status_consts.svh"

module drive_status_word_encoder (
	// Clock and reset
	input  wire logic                           sys_clk,
	input  wire logic                           rst,
	// Drive control inputs
	input  wire logic [15:0]                    control_word,
	input  wire logic                           init_done,
	input  wire logic                           fault_event,
	input  wire logic                           fault_react_done,
	input  wire logic                           quick_stop_done,
	// Compatibility setting
	input  wire logic [7:0]                     compat_ctrl,
	// Live event conditions
	input  wire drive_status_pkg::event_flags_t events,
	// Object read request
	input  wire logic                           obj_rd_req,
	input  wire logic [15:0]                    obj_index,
	// Object read answer
	output logic                                obj_rd_ack,
	output logic                                obj_rd_err,
	output logic [15:0]                         obj_rd_data,
	// Cyclic process data and state
	output logic [15:0]                         drive_status_word,
	output drive_status_pkg::drive_state_t      drive_state
);

	drive_status_pkg::encoder_core_t core_r;
	drive_status_pkg::encoder_core_t core_nxt;
	// Next state feeds both the state register and the encoder
	drive_status_pkg::drive_state_t  state_nxt;

	logic [15:0] state_bits;
	logic [15:0] word_nxt;
	logic        cmd_shutdown;
	logic        cmd_switch_on;
	logic        cmd_enable_op;
	logic        cmd_disable_op;
	logic        cmd_disable_volt;
	logic        cmd_quick_stop;
	logic        fault_rst_edge;
	logic        fault_std;
	logic        power_std;

	// Legacy forms are the reset default of both compatibility bits,
	// so earlier masters see nothing new unless software opts in
	assign fault_std = compat_ctrl[`COMPAT_BIT_FAULT];         // [RQ7]
	// Bit 4 keeps its inverted sense until bit 7 is set
	assign power_std = compat_ctrl[`COMPAT_BIT_POWER];

	// Command decode from the low control bits
	// Several codes overlap (enable and disable operation are both subsets of switch on);
	// the order of the if chains below decides which one wins
	assign cmd_disable_volt = ~control_word[`CW_BIT_VOLTAGE];
	assign cmd_quick_stop   = control_word[`CW_BIT_VOLTAGE]
	                        & ~control_word[`CW_BIT_QSTOP];
	assign cmd_shutdown     = control_word[2:0] == 3'h6;
	assign cmd_switch_on    = control_word[2:0] == 3'h7;
	assign cmd_enable_op    = cmd_switch_on
	                        & control_word[`CW_BIT_ENABLE_OP];
	assign cmd_disable_op   = cmd_switch_on
	                        & ~control_word[`CW_BIT_ENABLE_OP];
	// Only a rising bit 7 clears a fault, so a master that leaves the
	// bit set cannot keep wiping out a fault that comes back
	assign fault_rst_edge   = control_word[`CW_BIT_FAULT_RST]
	                        & ~core_r.fault_rst_prev;

	// Drive state machine; faults preempt every command
	always_comb begin
		state_nxt = core_r.state;
		unique case (core_r.state)
			drive_status_pkg::not_prepared_state: begin
				if (init_done) begin
					state_nxt = drive_status_pkg::disabled_state;
				end
			end
			drive_status_pkg::disabled_state: begin
				if (cmd_shutdown) begin
					state_nxt = drive_status_pkg::prepared_state;
				end
			end
			drive_status_pkg::prepared_state: begin
				if (cmd_disable_volt || cmd_quick_stop) begin
					state_nxt = drive_status_pkg::disabled_state;
				end else if (cmd_enable_op) begin
					// Switch on and enable taken in one step
					state_nxt = drive_status_pkg::op_enabled_state;
				end else if (cmd_switch_on) begin
					state_nxt = drive_status_pkg::switched_on_state;
				end
			end
			drive_status_pkg::switched_on_state: begin
				if (cmd_disable_volt || cmd_quick_stop) begin
					state_nxt = drive_status_pkg::disabled_state;
				end else if (cmd_shutdown) begin
					state_nxt = drive_status_pkg::prepared_state;
				end else if (cmd_enable_op) begin
					state_nxt = drive_status_pkg::op_enabled_state;
				end
			end
			drive_status_pkg::op_enabled_state: begin
				if (cmd_disable_volt) begin
					state_nxt = drive_status_pkg::disabled_state;
				end else if (cmd_quick_stop) begin
					state_nxt = drive_status_pkg::quick_stop_state;
				end else if (cmd_shutdown) begin
					state_nxt = drive_status_pkg::prepared_state;
				end else if (cmd_disable_op) begin
					state_nxt = drive_status_pkg::switched_on_state;
				end
			end
			drive_status_pkg::quick_stop_state: begin
				// Cutting the voltage ends the stop ramp at once
				if (cmd_disable_volt || quick_stop_done) begin
					state_nxt = drive_status_pkg::disabled_state;
				end
			end
			drive_status_pkg::fault_react_state: begin
				if (fault_react_done) begin
					state_nxt = drive_status_pkg::fault_state;
				end
			end
			drive_status_pkg::fault_state: begin
				// Reset only succeeds once the cause is gone
				if (fault_rst_edge && !fault_event) begin
					state_nxt = drive_status_pkg::disabled_state;
				end
			end
		endcase
		// A fault already being handled does not restart its reaction
		if (fault_event
		    && core_r.state != drive_status_pkg::fault_react_state
		    && core_r.state != drive_status_pkg::fault_state) begin
			state_nxt = drive_status_pkg::fault_react_state;
		end
	end

	// Encoding works on the next state so the word and the state
	// register change on the same edge
	state_bits_encoder u_state_bits (
		.state      (state_nxt),                              // [RQ13]
		.fault_std  (fault_std),
		.state_bits (state_bits)                              // [RQ1]
	);

	// Event flags are taken live each cycle, nothing is held
	// One flop stage on every flag keeps the outputs glitch free; the
	// word lags its inputs by exactly one clock and no more
	always_comb begin
		word_nxt = state_bits;
		word_nxt[`SW_BIT_POWER_STAGE] = power_std
		                              ? events.power_stage_on
		                              : ~events.power_stage_on;  // [RQ11]
		word_nxt[`SW_BIT_WARNING]     = events.warning;         // [RQ11]
		word_nxt[`SW_BIT_MOTION]      = events.motion_flag;     // [RQ11]
		word_nxt[`SW_BIT_NET_ENABLE]  = events.network_enable;  // [RQ11]
		word_nxt[`SW_BIT_GOAL]        = events.goal_attained;   // [RQ11]
		word_nxt[`SW_BIT_CUR_LIMIT]   = events.current_limit;   // [RQ11]
		word_nxt[`SW_BIT_MODE_ACK]    = events.mode_ack;        // [RQ11]
		word_nxt[`SW_BIT_TRACK_ERR]   = events.track_error;     // [RQ11]
		word_nxt[`SW_BIT_VENDOR]      = events.vendor_flag;     // [RQ11]
		word_nxt[`SW_BIT_CAPTURE]     = events.capture_result;  // [RQ11]
	end

	// Next core value
	// The read answer and the cyclic word share one next value, so a
	// read can never return an older word than the process data shows
	always_comb begin
		core_nxt                = core_r;
		core_nxt.state          = state_nxt;
		core_nxt.fault_rst_prev = control_word[`CW_BIT_FAULT_RST];
		core_nxt.word           = word_nxt;                   // [RQ10]
		core_nxt.rd.ack         = obj_rd_req;
		core_nxt.rd.err         = 1'b0;
		core_nxt.rd.data        = 16'h0000;
		if (obj_rd_req) begin
			if (obj_index == `SW_INDEX) begin
				// A read returns the word as it stands now
				core_nxt.rd.data = word_nxt;                  // [RQ10]
			end else begin
				// Refused with an error pulse so no master waits in vain
				core_nxt.rd.err  = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			core_r.state          <= drive_status_pkg::not_prepared_state;
			core_r.fault_rst_prev <= 1'b0;
			core_r.word           <= `SW_RESET_WORD;
			core_r.rd.ack         <= 1'b0;
			core_r.rd.err         <= 1'b0;
			core_r.rd.data        <= 16'h0000;
		end else begin
			core_r <= core_nxt;
		end
	end

	assign obj_rd_ack        = core_r.rd.ack;
	assign obj_rd_err        = core_r.rd.err;
	assign obj_rd_data       = core_r.rd.data;
	assign drive_status_word = core_r.word;
	assign drive_state       = core_r.state;

endmodule : drive_status_word_encoder

// ---- design/state_bits_encoder.sv ----
`timescale 1ns/10ps
`include "drive_status_consts.svh"

module state_bits_encoder (
	// Next drive state, the value the state register takes on the coming edge
	input  wire drive_status_pkg::drive_state_t state,
	// Fault indication select, high for standard form
	input  wire logic                           fault_std,
	// Status word with only bits 0,1,2,3,5,6 populated
	output logic [15:0]                         state_bits
);

	// Don't-care bit 5 is shown as zero wherever it is free
	always_comb begin
		unique case (state)
			drive_status_pkg::not_prepared_state:
				state_bits = `SW_VAL_NOT_PREP;            // [RQ2]
			drive_status_pkg::disabled_state:
				state_bits = `SW_VAL_DISABLED;            // [RQ2]
			drive_status_pkg::prepared_state:
				state_bits = `SW_VAL_PREPARED;            // [RQ3]
			drive_status_pkg::switched_on_state:
				state_bits = `SW_VAL_SWITCHED_ON;         // [RQ3]
			drive_status_pkg::op_enabled_state:
				state_bits = `SW_VAL_OP_ENABLED;          // [RQ4]
			drive_status_pkg::quick_stop_state:
				state_bits = `SW_VAL_QUICK_STOP;          // [RQ4]
			drive_status_pkg::fault_react_state:
				state_bits = `SW_VAL_FAULT_LEGACY;        // [RQ5]
			drive_status_pkg::fault_state: begin
				if (fault_std) begin
					state_bits = `SW_VAL_FAULT_STD;       // [RQ6]
				end else begin
					state_bits = `SW_VAL_FAULT_LEGACY;    // [RQ5]
				end
			end
		endcase
	end

endmodule : state_bits_encoder

// ---- testbench/drive_status_checker.sv ----
`timescale 1ns/10ps
module drive_status_checker (
	// Clock and reset
	input wire logic                           sys_clk,
	input wire logic                           rst,
	// Watched inputs
	input wire logic [7:0]                     compat_ctrl,
	input wire drive_status_pkg::event_flags_t events,
	input wire logic                           obj_rd_req,
	input wire logic [15:0]                    obj_index,
	// Watched outputs
	input wire logic                           obj_rd_ack,
	input wire logic                           obj_rd_err,
	input wire logic [15:0]                    obj_rd_data,
	input wire logic [15:0]                    drive_status_word,
	input wire drive_status_pkg::drive_state_t drive_state
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	not_ready_code_a: assert property (
		drive_state == drive_status_pkg::not_prepared_state
		|-> (drive_status_word & 16'h004F) == 16'h0000)
		else $error("not prepared code wrong");
	disabled_code_a: assert property (
		drive_state == drive_status_pkg::disabled_state
		|-> (drive_status_word & 16'h004F) == 16'h0040)
		else $error("disabled state code wrong");
	prepared_code_a: assert property (
		drive_state == drive_status_pkg::prepared_state
		|-> (drive_status_word & 16'h006F) == 16'h0021)
		else $error("prepared state code wrong");
	switched_code_a: assert property (
		drive_state == drive_status_pkg::switched_on_state
		|-> (drive_status_word & 16'h006F) == 16'h0023)
		else $error("switched on code wrong");
	enabled_code_a: assert property (
		drive_state == drive_status_pkg::op_enabled_state
		|-> (drive_status_word & 16'h006F) == 16'h0027)
		else $error("operation enabled code wrong");
	qstop_code_a: assert property (
		drive_state == drive_status_pkg::quick_stop_state
		|-> (drive_status_word & 16'h006F) == 16'h0007)
		else $error("quick stop code wrong");
	reaction_code_a: assert property (
		drive_state == drive_status_pkg::fault_react_state
		|-> (drive_status_word & 16'h004F) == 16'h000F)
		else $error("fault reaction code wrong");
	fault_code_a: assert property (
		drive_state == drive_status_pkg::fault_state && !$past(rst)
		|-> (drive_status_word & 16'h004F) ==
		($past(compat_ctrl[6]) ? 16'h0008 : 16'h000F))
		else $error("fault code wrong");
	event_bits_a: assert property (
		!$past(rst) |->
		drive_status_word[8] == $past(events.motion_flag)
		&& drive_status_word[15] == $past(events.capture_result)
		&& drive_status_word[7] == $past(events.warning)
		&& drive_status_word[14:9] == $past({events.vendor_flag,
		events.track_error, events.mode_ack, events.current_limit,
		events.goal_attained, events.network_enable})
		&& drive_status_word[4] ==
		($past(compat_ctrl[7]) ~^ $past(events.power_stage_on)))
		else $error("event bits wrong");
	read_answer_a: assert property (
		obj_rd_req |=> obj_rd_ack
		&& obj_rd_err == ($past(obj_index) != 16'h6041)
		&& obj_rd_data == (obj_rd_err ? 16'h0000 : drive_status_word))
		else $error("object read answer wrong");
endmodule : drive_status_checker

bind drive_status_word_encoder drive_status_checker i_drive_status_checker (
	.sys_clk, .rst, .compat_ctrl, .events, .obj_rd_req, .obj_index,
	.obj_rd_ack, .obj_rd_err, .obj_rd_data, .drive_status_word, .drive_state);

// ---- testbench/drive_status_word_encoder_tb.sv ----
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module drive_status_word_encoder_tb;
	logic                           sys_clk;
	logic                           go = 1'b0, init_done = 1'b0;
	logic                           rst = 1'b1, fault_event = 1'b0;
	logic                           obj_rd_req = 1'b0;
	logic                           fault_react_done = 1'b0;
	logic                           quick_stop_done = 1'b0;
	logic [7:0]                     compat_ctrl = 8'h00;
	logic [15:0]                    obj_index = 16'h0000, rnd = 16'h3DCD;
	logic [15:0]                    cmd = 16'h0000, mask = 16'h0000;
	logic [15:0]                    val = 16'h0000, control_word;
	logic [15:0]                    obj_rd_data, drive_status_word;
	logic                           obj_rd_ack, obj_rd_err, done;
	drive_status_pkg::event_flags_t events = '0;
	drive_status_pkg::drive_state_t drive_state;
	int                             n_mismatch = 0, checks_done = 0;

	drive_status_word_encoder i_drive_status_word_encoder (.sys_clk, .rst,
		.control_word, .init_done, .fault_event, .fault_react_done,
		.quick_stop_done, .compat_ctrl, .events, .obj_rd_req, .obj_index,
		.obj_rd_ack, .obj_rd_err, .obj_rd_data, .drive_status_word,
		.drive_state);
	fieldbus_master_model i_fieldbus_master_model (.sys_clk, .rst, .go,
		.cmd, .mask, .val, .status(drive_status_word), .control_word, .done);

	function automatic logic [15:0] xs(logic [15:0] x);
		x ^= x << 7;
		x ^= x >> 9;
		x ^= x << 8;
		return x;
	endfunction : xs

	// Bit 4 stays inverted unless compat bit 7 asks for the standard form
	function automatic logic [15:0] ev_exp(logic [9:0] e, logic p);
		return {e[0], e[1], e[2], e[3], e[4], e[5], e[6], e[7], e[8],
			2'b00, p ~^ e[9], 4'h0};
	endfunction : ev_exp

	task automatic complete_run();
		$display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run

	task automatic rd(logic [15:0] idx, logic [15:0] exp);
		@(posedge sys_clk);
		obj_rd_req <= 1'b1;
		obj_index  <= idx;
		@(posedge sys_clk);
		obj_rd_req <= 1'b0;
		#1;
		`CHK(obj_rd_ack, 1'b1)
		`CHK(obj_rd_err, idx != 16'h6041)
		`CHK(obj_rd_data & (mask | 16'hFF90), exp)
	endtask : rd

	// k holds compat bit 6, quick stop done, reaction done, fault, init;
	// s is the state code that the target state carries
	task automatic step(logic [15:0] c, logic [4:0] k, logic [15:0] m, v,
		logic [2:0] s);
		int          i;
		logic [15:0] e;
		@(posedge sys_clk);
		rnd = xs(rnd);
		{compat_ctrl[6], quick_stop_done, fault_react_done, fault_event,
			init_done} <= k;
		compat_ctrl[7] <= rnd[15];
		events         <= rnd[9:0];
		cmd            <= c;
		mask           <= m;
		val            <= v;
		go             <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		i = 0;
		do begin
			@(posedge sys_clk);
			#1;
			i++;
		end while (done !== 1'b1 && i < 20);
		e = v | ev_exp(rnd[9:0], rnd[15]);
		`CHK(done, 1'b1)
		`CHK(drive_status_word & (m | 16'hFF90), e)
		`CHK(drive_state, s)
		rd(16'h6041, e);
		rd(16'h6041 ^ {rnd[15:1], 1'b1}, 16'h0000);
	endtask : step

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	initial begin
		#20000;
		n_mismatch++;
		complete_run();
	end

	initial begin
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		step(16'h0000, 5'h00, 16'h004F, 16'h0000, 3'h0);
		step(16'h0000, 5'h01, 16'h004F, 16'h0040, 3'h1);
		step(16'h0006, 5'h01, 16'h006F, 16'h0021, 3'h3);
		step(16'h000F, 5'h01, 16'h006F, 16'h0027, 3'h6);
		step(16'h0007, 5'h01, 16'h006F, 16'h0023, 3'h2);
		step(16'h000F, 5'h01, 16'h006F, 16'h0027, 3'h6);
		step(16'h0002, 5'h01, 16'h006F, 16'h0007, 3'h7);
		step(16'h0002, 5'h09, 16'h004F, 16'h0040, 3'h1);
		step(16'h0002, 5'h03, 16'h004F, 16'h000F, 3'h5);
		step(16'h0002, 5'h07, 16'h004F, 16'h000F, 3'h4);
		step(16'h0002, 5'h17, 16'h004F, 16'h0008, 3'h4);
		step(16'h0002, 5'h07, 16'h004F, 16'h000F, 3'h4);
		step(16'h0080, 5'h01, 16'h004F, 16'h0040, 3'h1);
		complete_run();
	end
endmodule : drive_status_word_encoder_tb

// ---- testbench/fieldbus_master_model.sv ----
`timescale 1ns/10ps
module fieldbus_master_model (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Command to write and the state to wait for
	input  wire logic        go,
	input  wire logic [15:0] cmd,
	input  wire logic [15:0] mask,
	input  wire logic [15:0] val,
	input  wire logic [15:0] status,
	// Control word to the drive and arrival pulse
	output logic      [15:0] control_word,
	output logic             done
);
	logic busy_r;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			control_word <= 16'h0000;
			busy_r       <= 1'b0;
			done         <= 1'b0;
		end else begin
			done <= 1'b0;
			// Next command only once the word shows the target state
			if (go && !busy_r) begin
				control_word <= cmd;
				busy_r       <= 1'b1;
			end else if (busy_r && (status & mask) == val) begin
				busy_r <= 1'b0;
				done   <= 1'b1;
			end
		end
	end
endmodule : fieldbus_master_model
